// >>> pkg/isp_boot_map.svh
// Purpose: Offsets, field positions, reset values and unlock keys of the boot controller.
// Assumes: 32-bit APB, one aligned word per register, byte address = 4 * index.
// Notes: Definitions only.
`ifndef ISP_BOOT_MAP_SVH
`define ISP_BOOT_MAP_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define BOOT_CTRL_IDX 8'hbf
`define UNLOCK_KEY_IDX 8'hc0
`define BOOT_STATUS_IDX 8'hc1
`define REG_ADDR(idx) ({2'b00, (idx), 2'b00})
`define APB_ADDR_W 12

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_PROG_EN_BIT 0
`define CTRL_LOC_SEL_BIT 1
`define CTRL_AUX_RAM_BIT 4
`define CTRL_REBOOT_BIT 7
`define CTRL_RESET_VAL 8'h00

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define STAT_ISP_BIT 0
`define STAT_ARMED_BIT 1
`define STAT_UNLOCK_BIT 2
`define STAT_EXEC_LDR_BIT 3
`define STAT_STRAP_A_BIT 4
`define STAT_STRAP_B_BIT 5
`define STAT_STRAP_C_BIT 6

// ----------------------------------------
// Unlock keys and timing
// ----------------------------------------
`define UNLOCK_KEY_FIRST 8'h87
`define UNLOCK_KEY_SECOND 8'h59
`define STRAP_SETTLE_CYCLES 3

`endif

// >>> pkg/isp_boot_pkg.sv
// Purpose: Types shared by the boot and reprogramming controller.
// Assumes: Offsets and fields live in isp_boot_map.svh.
// Notes: States are one-hot.
package isp_boot_pkg;

  // ----------------------------------------
  // State and flash operation encodings
  // ----------------------------------------
  typedef enum logic [2:0] {
    KEY_LOCKED = 3'b001,
    KEY_FIRST = 3'b010,
    KEY_OPEN = 3'b100
  } unlock_state_t;

  typedef enum logic [2:0] {
    MODE_APP = 3'b001,
    MODE_ARMED = 3'b010,
    MODE_ISP = 3'b100
  } isp_mode_state_t;

  typedef enum logic [1:0] {
    FLASH_READ = 2'b00,
    FLASH_PROGRAM = 2'b01,
    FLASH_ERASE = 2'b10
  } flash_op_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    flash_op_t op;
  } flash_req_t;

  typedef struct packed {
    logic grant;
    logic refuse;
    logic target_loader;
  } flash_resp_t;

  typedef struct packed {
    logic isp_active;
    logic exec_loader;
    logic loader_in_loader_bank;
    logic target_loader;
    logic aux_ram_on;
  } boot_view_t;

endpackage

// >>> rtl/isp_boot_mode_control.sv
// Purpose: Boot source selection and in-system reprogramming control over APB.
// Assumes: core_idle, core_wake and flash_req come from logic on pclk.
// Notes: Straps pass a two-flop synchroniser and are latched once after power-on.
`include "isp_boot_map.svh"

module isp_boot_mode_control #(
  parameter int STRAP_SETTLE = `STRAP_SETTLE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boot_strap_a,
  input wire logic boot_strap_b,
  input wire logic boot_strap_c,
  input wire logic core_idle,
  input wire logic core_wake,
  input wire isp_boot_pkg::flash_req_t flash_req,
  output isp_boot_pkg::flash_resp_t flash_resp,
  output isp_boot_pkg::boot_view_t boot_view,
  output logic core_reboot,
  output logic pc_clear
);

  // Literal kept as a named word so single fields can be selected from it
  localparam logic [7:0] CTRL_RESET = `CTRL_RESET_VAL;

  initial begin
    if (STRAP_SETTLE < 3 || STRAP_SETTLE > 15) begin
      $error("STRAP_SETTLE must lie in 3..15");
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic addr_is(input logic [`APB_ADDR_W-1:0] a, input logic [7:0] idx);
    addr_is = (a == `REG_ADDR(idx));
  endfunction

  function automatic logic strap_forces(input logic a, input logic b, input logic c);
    strap_forces = (!a && !b) || !c;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [2:0] strap_s1_q;
  logic [2:0] strap_s2_q;
  logic [2:0] strap_hold_q, strap_hold_d;
  logic [3:0] settle_q, settle_d;
  logic sampled_q, sampled_d;
  logic forced_q, forced_d;
  logic prog_en_q, prog_en_d;
  logic loc_sel_q, loc_sel_d;
  logic aux_q, aux_d;
  isp_boot_pkg::unlock_state_t key_q, key_d;
  isp_boot_pkg::isp_mode_state_t mode_q, mode_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  isp_boot_pkg::flash_resp_t resp_q, resp_d;
  isp_boot_pkg::boot_view_t view_q, view_d;
  logic reboot_q, reboot_d;
  logic pc_clear_q, pc_clear_d;

  logic wr_fire;
  logic hit_ctrl, hit_key, hit_stat, hit_any;
  logic [7:0] wbyte;
  logic do_reboot;
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;

  assign hit_ctrl = addr_is(paddr, `BOOT_CTRL_IDX);
  assign hit_key = addr_is(paddr, `UNLOCK_KEY_IDX);
  assign hit_stat = addr_is(paddr, `BOOT_STATUS_IDX);
  assign hit_any = hit_ctrl || hit_key || hit_stat;
  assign wbyte = pwdata[7:0];
  assign wr_fire = psel && penable && pready_q && pwrite && !pslverr_q;

  // Only an open register accepts the reboot; both companion bits come from the same write
  assign do_reboot = wr_fire && hit_ctrl && (key_q == isp_boot_pkg::KEY_OPEN)
                     && wbyte[`CTRL_REBOOT_BIT] && wbyte[`CTRL_LOC_SEL_BIT]
                     && wbyte[`CTRL_PROG_EN_BIT];

  // ----------------------------------------
  // Strap synchroniser
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_q <= 3'h7;
      strap_s2_q <= 3'h7;
    end else begin
      strap_s1_q <= {boot_strap_c, boot_strap_b, boot_strap_a};
      strap_s2_q <= strap_s1_q;
    end
  end

  // ----------------------------------------
  // Boot source capture
  // ----------------------------------------
  // Wait until the synchroniser holds post-reset samples, then latch once
  always_comb begin
    settle_d = settle_q;
    sampled_d = sampled_q;
    strap_hold_d = strap_hold_q;
    forced_d = forced_q;
    if (!sampled_q) begin
      if (settle_q == 4'(STRAP_SETTLE - 1)) begin
        sampled_d = 1'b1;
        strap_hold_d = strap_s2_q;
        forced_d = strap_forces(strap_s2_q[0], strap_s2_q[1], strap_s2_q[2]);
      end else begin
        settle_d = settle_q + 4'h1;
      end
    end
    if (do_reboot) begin
      forced_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q <= 4'h0;
      sampled_q <= 1'b0;
      strap_hold_q <= 3'h7;
      forced_q <= 1'b0;
    end else begin
      settle_q <= settle_d;
      sampled_q <= sampled_d;
      strap_hold_q <= strap_hold_d;
      forced_q <= forced_d;
    end
  end

  // ----------------------------------------
  // Unlock sequence and control register
  // ----------------------------------------
  always_comb begin
    key_d = key_q;
    prog_en_d = prog_en_q;
    loc_sel_d = loc_sel_q;
    aux_d = aux_q;
    if (wr_fire && hit_key) begin
      if (wbyte == `UNLOCK_KEY_FIRST) begin
        if (key_q != isp_boot_pkg::KEY_OPEN) begin
          key_d = isp_boot_pkg::KEY_FIRST;
        end
      end else if (wbyte == `UNLOCK_KEY_SECOND) begin
        if (key_q == isp_boot_pkg::KEY_FIRST) begin
          key_d = isp_boot_pkg::KEY_OPEN;
        end
      end else begin
        key_d = isp_boot_pkg::KEY_LOCKED;
      end
    end
    if (wr_fire && hit_ctrl && key_q == isp_boot_pkg::KEY_OPEN) begin
      prog_en_d = wbyte[`CTRL_PROG_EN_BIT];
      loc_sel_d = wbyte[`CTRL_LOC_SEL_BIT];
      aux_d = wbyte[`CTRL_AUX_RAM_BIT];
    end
    if (do_reboot) begin
      key_d = isp_boot_pkg::KEY_LOCKED;
      prog_en_d = CTRL_RESET[`CTRL_PROG_EN_BIT];
      loc_sel_d = CTRL_RESET[`CTRL_LOC_SEL_BIT];
      aux_d = CTRL_RESET[`CTRL_AUX_RAM_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= isp_boot_pkg::KEY_LOCKED;
      prog_en_q <= 1'b0;
      loc_sel_q <= 1'b0;
      aux_q <= 1'b0;
    end else begin
      key_q <= key_d;
      prog_en_q <= prog_en_d;
      loc_sel_q <= loc_sel_d;
      aux_q <= aux_d;
    end
  end

  // ----------------------------------------
  // Programming mode sequencing
  // ----------------------------------------
  always_comb begin
    mode_d = mode_q;
    pc_clear_d = 1'b0;
    reboot_d = do_reboot;
    resp_d = '0;
    case (mode_q)
      isp_boot_pkg::MODE_APP: begin
        if (prog_en_q && core_idle) begin
          mode_d = isp_boot_pkg::MODE_ARMED;
        end
      end
      isp_boot_pkg::MODE_ARMED: begin
        if (!prog_en_q) begin
          mode_d = isp_boot_pkg::MODE_APP;
        end else if (core_wake) begin
          mode_d = isp_boot_pkg::MODE_ISP;
          pc_clear_d = loc_sel_q && !forced_q;
        end
      end
      isp_boot_pkg::MODE_ISP: begin
        if (!prog_en_q) begin
          mode_d = isp_boot_pkg::MODE_APP;
        end
      end
      default: begin
        mode_d = isp_boot_pkg::MODE_APP;
      end
    endcase
    // Reads pass outside programming mode; erase and program need it plus idle
    if (flash_req.valid) begin
      if (flash_req.op != isp_boot_pkg::FLASH_READ && !prog_en_q) begin
        resp_d.refuse = 1'b1;
      end else if (mode_q == isp_boot_pkg::MODE_ISP && !core_idle) begin
        resp_d.refuse = 1'b1;
      end else if (flash_req.op != isp_boot_pkg::FLASH_READ
                   && mode_q != isp_boot_pkg::MODE_ISP) begin
        resp_d.refuse = 1'b1;
      end else begin
        resp_d.grant = 1'b1;
      end
    end
    resp_d.target_loader = !loc_sel_d;
    if (do_reboot) begin
      mode_d = isp_boot_pkg::MODE_APP;
      pc_clear_d = 1'b0;
    end
  end

  always_comb begin
    view_d.isp_active = (mode_d == isp_boot_pkg::MODE_ISP);
    view_d.loader_in_loader_bank = loc_sel_d;
    view_d.target_loader = !loc_sel_d;
    view_d.exec_loader = forced_d || (view_d.isp_active && loc_sel_d);
    view_d.aux_ram_on = aux_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= isp_boot_pkg::MODE_APP;
      pc_clear_q <= 1'b0;
      reboot_q <= 1'b0;
      resp_q <= '0;
      view_q <= '0;
    end else begin
      mode_q <= mode_d;
      pc_clear_q <= pc_clear_d;
      reboot_q <= reboot_d;
      resp_q <= resp_d;
      view_q <= view_d;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Answer prepared in the setup cycle so every bus output is a flop with no wait state
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`CTRL_REBOOT_BIT] = forced_q;
    ctrl_rd[`CTRL_AUX_RAM_BIT] = aux_q;
    ctrl_rd[`CTRL_LOC_SEL_BIT] = loc_sel_q;
    ctrl_rd[`CTRL_PROG_EN_BIT] = prog_en_q;
    stat_rd = 8'h00;
    stat_rd[`STAT_ISP_BIT] = (mode_q == isp_boot_pkg::MODE_ISP);
    stat_rd[`STAT_ARMED_BIT] = (mode_q == isp_boot_pkg::MODE_ARMED);
    stat_rd[`STAT_UNLOCK_BIT] = (key_q == isp_boot_pkg::KEY_OPEN);
    stat_rd[`STAT_EXEC_LDR_BIT] = view_q.exec_loader;
    stat_rd[`STAT_STRAP_A_BIT] = strap_hold_q[0];
    stat_rd[`STAT_STRAP_B_BIT] = strap_hold_q[1];
    stat_rd[`STAT_STRAP_C_BIT] = strap_hold_q[2];
    pready_d = psel && !penable;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (psel && !penable) begin
      pslverr_d = !hit_any;
      prdata_d = 32'h0000_0000;
      if (!pwrite && hit_ctrl) begin
        prdata_d = {24'h00_0000, ctrl_rd};
      end else if (!pwrite && hit_stat) begin
        prdata_d = {24'h00_0000, stat_rd};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign flash_resp = resp_q;
  assign boot_view = view_q;
  assign core_reboot = reboot_q;
  assign pc_clear = pc_clear_q;

endmodule

// >>> sim/isp_boot_mode_control_chk.sv
// Purpose: Port-level checks of the boot and reprogramming controller.
// Assumes: Zero-wait APB, registered one-cycle response pulses.
// Notes: Bound from the testbench top file.
`include "isp_boot_map.svh"
module isp_boot_mode_control_chk #(
  parameter int STRAP_SETTLE = `STRAP_SETTLE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic boot_strap_a,
  input wire logic boot_strap_b,
  input wire logic boot_strap_c,
  input wire logic core_idle,
  input wire logic core_wake,
  input wire isp_boot_pkg::flash_req_t flash_req,
  input wire isp_boot_pkg::flash_resp_t flash_resp,
  input wire isp_boot_pkg::boot_view_t boot_view,
  input wire logic core_reboot,
  input wire logic pc_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic reboot_wr;
  logic prog_op;
  assign reboot_wr = psel && penable && pwrite && paddr == `REG_ADDR(`BOOT_CTRL_IDX)
    && pwdata[7] && pwdata[1] && pwdata[0];
  assign prog_op = flash_req.valid && flash_req.op != isp_boot_pkg::FLASH_READ;
  property p_reboot_cause;
    core_reboot |-> ($past(reboot_wr) || $past(reboot_wr, 2)) ##1 !core_reboot;
  endproperty
  a_reboot_cause: assert property (p_reboot_cause) else $error("reboot without trigger");
  property p_reboot_normal;
    core_reboot |-> ##2 !boot_view.isp_active && !boot_view.exec_loader;
  endproperty
  a_reboot_normal: assert property (p_reboot_normal) else $error("not normal after reboot");
  property p_target_bank;
    $past(presetn, 2) |-> boot_view.target_loader != boot_view.loader_in_loader_bank;
  endproperty
  a_target_bank: assert property (p_target_bank) else $error("target equals loader bank");
  property p_ro_refuse;
    prog_op && !boot_view.isp_active |=> flash_resp.refuse && !flash_resp.grant;
  endproperty
  a_ro_refuse: assert property (p_ro_refuse) else $error("write op outside programming");
  property p_idle_only;
    flash_req.valid && boot_view.isp_active && !core_idle |=> flash_resp.refuse;
  endproperty
  a_idle_only: assert property (p_idle_only) else $error("op ran while core awake");
  property p_resp_cause;
    flash_resp.grant || flash_resp.refuse |-> $past(flash_req.valid)
      && !(flash_resp.grant && flash_resp.refuse);
  endproperty
  a_resp_cause: assert property (p_resp_cause) else $error("stray flash response");
  property p_isp_wake;
    $rose(boot_view.isp_active) |-> $past(core_wake) || $past(core_wake, 2);
  endproperty
  a_isp_wake: assert property (p_isp_wake) else $error("programming without wake");
  property p_pc_clear;
    pc_clear |-> ($past(core_wake) || $past(core_wake, 2)) ##1 !pc_clear;
  endproperty
  a_pc_clear: assert property (p_pc_clear) else $error("pc clear without wake");
  property p_apb_answer;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing");
endmodule

// >>> sim/strap_switch_model.sv
// Purpose: Board strap switches held through power-on, then let go.
// Assumes: Strap lines have pull-ups, so a released switch reads high.
// Notes: The level to hold is given by the testbench before reset.
module strap_switch_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] strap_set,
  output logic boot_strap_a,
  output logic boot_strap_b,
  output logic boot_strap_c
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hold_q;
  logic [3:0] hold_d;
  // Release well after capture so a late sample in the design would show up
  always_comb begin
    hold_d = (hold_q == 4'h8) ? hold_q : hold_q + 4'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_q <= 4'h0;
    else hold_q <= hold_d;
  end
  assign {boot_strap_c, boot_strap_b, boot_strap_a} =
    (hold_q == 4'h8) ? 3'b111 : strap_set;
endmodule

// >>> sim/test_isp_boot_mode_control.sv
// Purpose: Register, strap, flash and reboot tests of the boot controller.
// Assumes: Zero-wait APB slave, 8-bit registers in the low byte.
// Notes: Strap cases end with a normal boot so programming entry clears the counter.
`include "isp_boot_map.svh"
module test_isp_boot_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] CTRL = `REG_ADDR(`BOOT_CTRL_IDX);
  localparam logic [11:0] KEY = `REG_ADDR(`UNLOCK_KEY_IDX);
  localparam logic [11:0] STAT = `REG_ADDR(`BOOT_STATUS_IDX);
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, rerr, boot_strap_a, boot_strap_b, boot_strap_c;
  logic core_idle = 0, core_wake = 0, core_reboot, pc_clear, pc_seen = 0, boot_seen = 0;
  logic [2:0] strap_set = 3'b111;
  isp_boot_pkg::flash_req_t flash_req = '0;
  isp_boot_pkg::flash_resp_t flash_resp;
  isp_boot_pkg::boot_view_t boot_view;
  int miscompares = 0, compares = 0, cycles = 0;
  logic [2:0] cases [4] = '{3'b111, 3'b100, 3'b011, 3'b110};
  isp_boot_mode_control i_isp_boot_mode_control (.*);
  strap_switch_model i_strap_switch_model (.*);
  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (pc_clear === 1'b1) pc_seen <= 1;
    if (core_reboot === 1'b1) boot_seen <= 1;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h", $time, m, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string m);
    apb(0, a, 0);
    chk(rdat, e, m);
  endtask
  task automatic fl(input isp_boot_pkg::flash_op_t op, input logic idle, input logic g);
    @(posedge pclk);
    flash_req <= '{1'b1, op}; core_idle <= idle;
    @(posedge pclk);
    flash_req.valid <= 0;
    @(posedge pclk);
    chk({flash_resp.grant, flash_resp.refuse}, {g, !g}, "flash response");
  endtask
  task automatic pulse_wake;
    @(posedge pclk); core_wake <= 1;
    @(posedge pclk); core_wake <= 0; core_idle <= 0;
    repeat (3) @(posedge pclk);
  endtask
  initial begin
    // ----------------------------------------
    // Strap sampling at power-on
    // ----------------------------------------
    foreach (cases[i]) begin
      logic f;
      strap_set = cases[i];
      f = !cases[i][2] || cases[i][1:0] == 2'b00;
      presetn <= 0;
      repeat (4) @(posedge pclk);
      presetn <= 1;
      repeat (12) @(posedge pclk);
      rd(CTRL, {24'h0, f, 7'h0}, "forced flag");
      rd(STAT, {25'h0, cases[i], f, 3'h0}, "latched straps");
      chk(boot_view.exec_loader, f, "boot source");
    end
    $display("test straps done");
    // ----------------------------------------
    // Unlock sequence and control fields
    // ----------------------------------------
    apb(1, CTRL, 32'h0000_0010);
    rd(CTRL, 32'h0000_0000, "locked write");
    apb(1, KEY, `UNLOCK_KEY_FIRST);
    apb(1, KEY, `UNLOCK_KEY_SECOND);
    apb(1, CTRL, 32'h0000_0012);
    rd(CTRL, 32'h0000_0012, "open write");
    chk({boot_view.aux_ram_on, boot_view.target_loader, flash_resp.target_loader,
         boot_view.loader_in_loader_bank}, 4'b1001, "bank view");
    apb(1, KEY, 32'h0000_0033);
    apb(1, CTRL, 32'h0000_0000);
    rd(CTRL, 32'h0000_0012, "closed by bad key");
    apb(1, KEY, `UNLOCK_KEY_SECOND);
    apb(1, KEY, `UNLOCK_KEY_FIRST);
    apb(1, CTRL, 32'h0000_0000);
    rd(CTRL, 32'h0000_0012, "key order");
    apb(1, KEY, `UNLOCK_KEY_SECOND);
    apb(1, CTRL, 32'h0000_0010);
    // Views update at the access edge, so look one edge later
    @(posedge pclk);
    chk({boot_view.aux_ram_on, boot_view.target_loader, flash_resp.target_loader,
         boot_view.loader_in_loader_bank}, 4'b1110, "app target");
    apb(1, CTRL, 32'h0000_0000);
    @(posedge pclk);
    chk(boot_view.aux_ram_on, 1'b0, "aux off");
    $display("test unlock done");
    // ----------------------------------------
    // Flash read-only, then programming mode
    // ----------------------------------------
    fl(isp_boot_pkg::FLASH_PROGRAM, 1, 0);
    fl(isp_boot_pkg::FLASH_ERASE, 1, 0);
    fl(isp_boot_pkg::FLASH_READ, 0, 1);
    apb(1, CTRL, 32'h0000_0003);
    pulse_wake;
    chk(boot_view.isp_active, 1'b0, "wake without idle");
    @(posedge pclk); core_idle <= 1;
    repeat (2) @(posedge pclk);
    pulse_wake;
    chk({boot_view.isp_active, boot_view.exec_loader, pc_seen}, 3'b111, "enter isp");
    fl(isp_boot_pkg::FLASH_ERASE, 1, 1);
    fl(isp_boot_pkg::FLASH_PROGRAM, 0, 0);
    fl(isp_boot_pkg::FLASH_READ, 0, 0);
    $display("test flash done");
    // ----------------------------------------
    // Soft reboot back to normal operation
    // ----------------------------------------
    apb(1, CTRL, 32'h0000_0083);
    repeat (3) @(posedge pclk);
    chk(boot_seen, 1'b1, "reboot pulse");
    rd(CTRL, 32'h0000_0000, "control after reboot");
    chk({boot_view.isp_active, boot_view.exec_loader}, 2'b00, "normal run");
    // Forced boot must also give way to normal operation after a soft reboot
    strap_set = 3'b100;
    presetn <= 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (12) @(posedge pclk);
    apb(1, KEY, `UNLOCK_KEY_FIRST);
    apb(1, KEY, `UNLOCK_KEY_SECOND);
    apb(1, CTRL, 32'h0000_0083);
    repeat (3) @(posedge pclk);
    rd(CTRL, 32'h0000_0000, "forced flag after reboot");
    chk(boot_view.exec_loader, 1'b0, "forced boot left");
    apb(1, CTRL, 32'h0000_0010);
    rd(CTRL, 32'h0000_0000, "key relocked");
    apb(0, 12'h010, 0);
    chk(rerr, 1'b1, "unmapped error");
    chk(rdat, 32'h0000_0000, "unmapped data");
    $display("test reboot done");
    print_verdict;
  end
endmodule
bind isp_boot_mode_control isp_boot_mode_control_chk #(.STRAP_SETTLE(STRAP_SETTLE)) i_chk (.*);
